// ===== pkg/cfg_loader_consts.vh
// Register offsets, field positions, codes and reset values of the configuration decoder
`ifndef CFG_LOADER_CONSTS_VH
`define CFG_LOADER_CONSTS_VH

`define AXI_AW            8
`define AXI_DW            32
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define OFS_CFG_ONE       8'h00
`define OFS_CFG_TWO       8'h04
`define OFS_CONTROL       8'h08
`define OFS_STATUS        8'h0c

`define CFG_W             14
`define CFG_ERASED        14'h3fff
`define CFG_TWO_UNIMPL    14'h08fc

`define ONE_OSC_LSB       0
`define ONE_OSC_MSB       2
`define ONE_PUD_N         5
`define ONE_PROG_N        7
`define ONE_EE_N          8
`define ONE_BOR_LSB       9
`define ONE_BOR_MSB       10
`define TWO_SWP_LSB       0
`define TWO_SWP_MSB       1
`define TWO_PLL           8
`define TWO_STV           9
`define TWO_TRIP          10
`define TWO_LOWV          13

`define CTRL_ERASE        0
`define CTRL_CLR_FAULT    1

`define OSC_EXT_HI        3'h7
`define OSC_EXT_MID       3'h6
`define OSC_EXT_LO        3'h5
`define OSC_INT           3'h4
`define OSC_RC            3'h3
`define OSC_XTAL_HI       3'h2
`define OSC_XTAL_MID      3'h1
`define OSC_XTAL_LO       3'h0

`define SRC_EXT_CLOCK     2'h0
`define SRC_INTERNAL      2'h1
`define SRC_EXT_RC        2'h2
`define SRC_CRYSTAL       2'h3
`define RANGE_HIGH        2'h2
`define RANGE_MEDIUM      2'h1
`define RANGE_LOW         2'h0

`define SWP_OFF           2'h3
`define SWP_LOW_BLOCK     2'h2
`define SWP_MID_BLOCK     2'h1
`define SWP_LIMIT_LOW     12'h1ff
`define SWP_LIMIT_MID     12'h7ff
`define SWP_LIMIT_ALL     12'hfff

`endif

// ===== src/osc_decode.v
// Oscillator-select decoder, captured once at power-up load
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.vh"

module osc_decode (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       load,
    input  wire [2:0] osc_select,
    output reg  [1:0] clock_source,
    output reg  [1:0] drive_range,
    output reg        clock_pin_gpio,
    output reg        startup_bypass
);

    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_source   <= `SRC_INTERNAL;
            drive_range    <= `RANGE_LOW;
            clock_pin_gpio <= 1'b0;
            startup_bypass <= 1'b0;
        end else if (load) begin
            clock_pin_gpio <= 1'b0;
            startup_bypass <= 1'b0;
            drive_range    <= `RANGE_LOW;
            case (osc_select)
                `OSC_EXT_HI, `OSC_EXT_MID, `OSC_EXT_LO: begin
                    clock_source   <= `SRC_EXT_CLOCK;
                    startup_bypass <= 1'b1;
                    if (osc_select == `OSC_EXT_HI)
                        drive_range <= `RANGE_HIGH;
                    else if (osc_select == `OSC_EXT_MID)
                        drive_range <= `RANGE_MEDIUM;
                end
                `OSC_INT: begin
                    clock_source   <= `SRC_INTERNAL;
                    clock_pin_gpio <= 1'b1;
                end
                `OSC_RC: begin
                    clock_source <= `SRC_EXT_RC;
                end
                `OSC_XTAL_HI: begin
                    clock_source <= `SRC_CRYSTAL;
                    drive_range  <= `RANGE_HIGH;
                end
                `OSC_XTAL_MID: begin
                    clock_source <= `SRC_CRYSTAL;
                    drive_range  <= `RANGE_MEDIUM;
                end
                default: begin
                    clock_source <= `SRC_CRYSTAL;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== src/access_gate.v
// Gates external and CPU accesses to program memory and data EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.vh"

module access_gate (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        program_protect_n,
    input  wire        eeprom_protect_n,
    input  wire [1:0]  self_write_protect_range,
    input  wire        cpu_pm_rd_req,
    input  wire        cpu_pm_wr_req,
    input  wire [11:0] cpu_pm_wr_addr,
    input  wire        cpu_ee_req,
    input  wire        ext_req,
    input  wire        ext_write,
    input  wire        ext_space,
    input  wire [13:0] ext_mem_rdata,
    output reg         cpu_pm_rd_grant,
    output reg         cpu_pm_wr_en,
    output reg         cpu_pm_wr_blocked,
    output reg         cpu_ee_grant,
    output reg         ext_mem_write,
    output reg  [13:0] ext_rdata,
    output reg         ext_ack,
    output reg         ext_refused
);

    // High when the address falls inside the self-write locked block
    function locked;
        input [1:0]  range;
        input [11:0] addr;
        begin
            case (range)
                `SWP_OFF:       locked = 1'b0;
                `SWP_LOW_BLOCK: locked = (addr <= `SWP_LIMIT_LOW);
                `SWP_MID_BLOCK: locked = (addr <= `SWP_LIMIT_MID);
                default:        locked = (addr <= `SWP_LIMIT_ALL);
            endcase
        end
    endfunction

    wire ext_blocked;
    // Space 0 is program memory, space 1 is data EEPROM
    assign ext_blocked = ext_space ? !eeprom_protect_n : !program_protect_n;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_pm_rd_grant   <= 1'b0;
            cpu_pm_wr_en      <= 1'b0;
            cpu_pm_wr_blocked <= 1'b0;
            cpu_ee_grant      <= 1'b0;
            ext_mem_write     <= 1'b0;
            ext_rdata         <= 14'h0000;
            ext_ack           <= 1'b0;
            ext_refused       <= 1'b0;
        end else begin
            // Internal paths never look at the code-protection bits; only the CPU program write checks the self-write range
            cpu_pm_rd_grant   <= cpu_pm_rd_req;
            cpu_ee_grant      <= cpu_ee_req;
            cpu_pm_wr_en      <= cpu_pm_wr_req && !locked(self_write_protect_range, cpu_pm_wr_addr);
            cpu_pm_wr_blocked <= cpu_pm_wr_req && locked(self_write_protect_range, cpu_pm_wr_addr);
            ext_ack           <= ext_req;
            ext_refused       <= ext_req && ext_blocked;
            ext_mem_write     <= ext_req && ext_write && !ext_blocked;
            if (ext_req && !ext_write)
                ext_rdata <= ext_blocked ? 14'h0000 : ext_mem_rdata;
        end
    end

endmodule
`default_nettype wire

// ===== src/config_word_decode_code_protect.v
// Configuration word loader, decoder and code protection with AXI4-Lite access
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.vh"

module config_word_decode_code_protect (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  awaddr,
    input  wire [2:0]  awprot,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire [2:0]  arprot,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    input  wire [13:0] nv_word_one,
    input  wire [13:0] nv_word_two,
    input  wire        stack_overflow,
    input  wire        stack_underflow,
    input  wire        cpu_pm_rd_req,
    input  wire        cpu_pm_wr_req,
    input  wire [11:0] cpu_pm_wr_addr,
    input  wire        cpu_ee_req,
    input  wire        ext_req,
    input  wire        ext_write,
    input  wire        ext_space,
    input  wire [13:0] ext_mem_rdata,
    output wire [1:0]  clock_source,
    output wire [1:0]  drive_range,
    output wire        clock_pin_gpio,
    output wire        startup_bypass,
    output reg         pll_enable,
    output reg         stack_fault_reset,
    output reg         power_up_delay_enable,
    output reg  [1:0]  brownout_mode,
    output reg         brownout_trip_select,
    output reg         low_voltage_programming,
    output reg         master_clear_hv_required,
    output reg         program_erase,
    output reg         eeprom_erase,
    output reg         config_loaded,
    output wire        cpu_pm_rd_grant,
    output wire        cpu_pm_wr_en,
    output wire        cpu_pm_wr_blocked,
    output wire        cpu_ee_grant,
    output wire        ext_mem_write,
    output wire [13:0] ext_rdata,
    output wire        ext_ack,
    output wire        ext_refused
);

    localparam ST_LOAD = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg         state;
    reg         load_pulse;
    reg  [13:0] config_word_one;
    reg  [13:0] config_word_two;
    reg         stack_fault_seen;

    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire        do_write;
    wire [13:0] wr_bits;
    wire        erase_cmd;
    wire        clr_fault_cmd;
    wire        fault_event;

    // Applies the byte strobes to a 14-bit word; lanes above the word are dropped
    function [13:0] strobe_merge;
        input [13:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            strobe_merge = old;
            if (strb[0])
                strobe_merge[7:0] = data[7:0];
            if (strb[1])
                strobe_merge[13:8] = data[13:8];
        end
    endfunction

    // Decodes a byte address into a mapped-register flag
    function mapped;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `OFS_CFG_ONE,
                `OFS_CFG_TWO,
                `OFS_CONTROL,
                `OFS_STATUS: mapped = 1'b1;
                default:     mapped = 1'b0;
            endcase
        end
    endfunction

    assign do_write      = aw_held && w_held && !bvalid;
    assign wr_bits       = strobe_merge(`CFG_ERASED, w_data, w_strb);
    assign erase_cmd     = do_write && ({aw_addr[7:2], 2'b00} == `OFS_CONTROL)
                           && w_strb[0] && w_data[`CTRL_ERASE];
    assign clr_fault_cmd = do_write && ({aw_addr[7:2], 2'b00} == `OFS_CONTROL)
                           && w_strb[0] && w_data[`CTRL_CLR_FAULT];
    assign fault_event   = stack_overflow || stack_underflow;

    // Power-up load: the words are taken from the nonvolatile array once after reset
    // Nothing else samples the array, so the clock choice stays put until reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            state         <= ST_LOAD;
            load_pulse    <= 1'b0;
            config_loaded <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            case (state)
                ST_LOAD: begin
                    load_pulse    <= 1'b1;
                    config_loaded <= 1'b1;
                    state         <= ST_RUN;
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_LOAD;
                end
            endcase
        end
    end

    // Programming only clears bits; only a bulk erase sets them back to one,
    // so protection can never be lifted without the matching erase.
    always @(posedge aclk) begin
        if (!aresetn) begin
            config_word_one <= `CFG_ERASED;
            config_word_two <= `CFG_ERASED;
            program_erase   <= 1'b0;
            eeprom_erase    <= 1'b0;
        end else begin
            program_erase <= 1'b0;
            eeprom_erase  <= 1'b0;
            if (state == ST_LOAD) begin
                config_word_one <= nv_word_one;
                config_word_two <= nv_word_two | `CFG_TWO_UNIMPL;
            end else if (erase_cmd) begin
                config_word_one <= `CFG_ERASED;
                config_word_two <= `CFG_ERASED;
                // Each pulse reports a protection that this erase lifted
                program_erase   <= !config_word_one[`ONE_PROG_N];
                eeprom_erase    <= !config_word_one[`ONE_EE_N];
            end else if (do_write) begin
                if ({aw_addr[7:2], 2'b00} == `OFS_CFG_ONE)
                    config_word_one <= config_word_one & wr_bits;
                if ({aw_addr[7:2], 2'b00} == `OFS_CFG_TWO)
                    config_word_two <= (config_word_two & wr_bits) | `CFG_TWO_UNIMPL;
            end
        end
    end

    // Decoded settings that follow the stored words
    // One cycle of latency keeps every decoded output straight from a flop
    always @(posedge aclk) begin
        if (!aresetn) begin
            pll_enable               <= 1'b0;
            power_up_delay_enable    <= 1'b0;
            brownout_mode            <= 2'h0;
            brownout_trip_select     <= 1'b0;
            low_voltage_programming  <= 1'b0;
            master_clear_hv_required <= 1'b0;
        end else begin
            pll_enable               <= config_word_two[`TWO_PLL];
            // Each timer follows only its own field
            power_up_delay_enable    <= !config_word_one[`ONE_PUD_N];
            brownout_mode            <= config_word_one[`ONE_BOR_MSB:`ONE_BOR_LSB];
            brownout_trip_select     <= config_word_two[`TWO_TRIP];
            low_voltage_programming  <= config_word_two[`TWO_LOWV];
            master_clear_hv_required <= !config_word_two[`TWO_LOWV];
        end
    end

    // Stack fault reset; a new fault beats a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            stack_fault_reset <= 1'b0;
            stack_fault_seen  <= 1'b0;
        end else begin
            stack_fault_reset <= fault_event && config_word_two[`TWO_STV];
            if (fault_event)
                stack_fault_seen <= 1'b1;
            else if (clr_fault_cmd)
                stack_fault_seen <= 1'b0;
        end
    end

    // AXI4-Lite write channels, taken in either order
    // A new address or data beat may be taken while the response still waits
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
                wready <= 1'b0;
            end
            if (bvalid && bready)
                bvalid <= 1'b0;
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
                bvalid  <= 1'b1;
                bresp   <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // AXI4-Lite read channel
    // arready stays low until the answer is taken, so one read is open at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else begin
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
                case ({araddr[7:2], 2'b00})
                    `OFS_CFG_ONE: rdata <= {18'h00000, config_word_one};
                    `OFS_CFG_TWO: rdata <= {18'h00000, config_word_two};
                    `OFS_STATUS:  rdata <= {25'h0000000,
                                            !config_word_one[`ONE_EE_N],
                                            !config_word_one[`ONE_PROG_N],
                                            startup_bypass,
                                            clock_source,
                                            stack_fault_seen,
                                            config_loaded};
                    default:      rdata <= 32'h00000000;
                endcase
            end
        end
    end

    osc_decode u_osc_decode (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .load           (load_pulse),
        .osc_select     (config_word_one[`ONE_OSC_MSB:`ONE_OSC_LSB]),
        .clock_source   (clock_source),
        .drive_range    (drive_range),
        .clock_pin_gpio (clock_pin_gpio),
        .startup_bypass (startup_bypass)
    );

    access_gate u_access_gate (
        .aclk                     (aclk),
        .aresetn                  (aresetn),
        .program_protect_n        (config_word_one[`ONE_PROG_N]),
        .eeprom_protect_n         (config_word_one[`ONE_EE_N]),
        .self_write_protect_range (config_word_two[`TWO_SWP_MSB:`TWO_SWP_LSB]),
        .cpu_pm_rd_req            (cpu_pm_rd_req),
        .cpu_pm_wr_req            (cpu_pm_wr_req),
        .cpu_pm_wr_addr           (cpu_pm_wr_addr),
        .cpu_ee_req               (cpu_ee_req),
        .ext_req                  (ext_req),
        .ext_write                (ext_write),
        .ext_space                (ext_space),
        .ext_mem_rdata            (ext_mem_rdata),
        .cpu_pm_rd_grant          (cpu_pm_rd_grant),
        .cpu_pm_wr_en             (cpu_pm_wr_en),
        .cpu_pm_wr_blocked        (cpu_pm_wr_blocked),
        .cpu_ee_grant             (cpu_ee_grant),
        .ext_mem_write            (ext_mem_write),
        .ext_rdata                (ext_rdata),
        .ext_ack                  (ext_ack),
        .ext_refused              (ext_refused)
    );

endmodule
`default_nettype wire

// ===== bench/cfg_checker_assertions.sv
// Port-level checker for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.vh"
module cfg_checker (
    input wire logic        aclk, aresetn, awvalid, awready, bvalid, bready, arvalid, arready, rvalid,
    input wire logic [1:0]  bresp, clock_source,
    input wire logic        cpu_pm_rd_req, cpu_pm_rd_grant, cpu_ee_req, cpu_ee_grant, cpu_pm_wr_req,
    input wire logic        cpu_pm_wr_en, cpu_pm_wr_blocked, ext_req, ext_write, ext_ack, ext_refused,
    input wire logic        ext_mem_write, stack_overflow, stack_underflow, stack_fault_reset,
    input wire logic        program_erase, clock_pin_gpio, startup_bypass, config_loaded,
    input wire logic [13:0] ext_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    gpio_match_a: assert property (config_loaded [*4] |-> clock_pin_gpio == (clock_source == `SRC_INTERNAL))
        else $error("clock pin release disagrees with clock source");
    ext_bypass_a: assert property (config_loaded [*4] |-> startup_bypass == (clock_source == `SRC_EXT_CLOCK))
        else $error("start-up bypass disagrees with clock source");
    cpu_read_grant_a: assert property (cpu_pm_rd_req |=> cpu_pm_rd_grant)
        else $error("cpu program read not granted");
    cpu_ee_grant_a: assert property (cpu_ee_req |=> cpu_ee_grant)
        else $error("cpu eeprom access not granted");
    cpu_write_gate_a: assert property (cpu_pm_wr_req |=> cpu_pm_wr_en != cpu_pm_wr_blocked)
        else $error("cpu program write neither enabled nor blocked");
    ext_answer_a: assert property (ext_req |=> ext_ack)
        else $error("programmer request not answered");
    refused_no_write_a: assert property (ext_refused |-> !ext_mem_write)
        else $error("refused access still wrote memory");
    refused_zero_a: assert property (ext_req && !ext_write ##1 ext_refused |-> ext_rdata == 14'h0)
        else $error("refused read returned nonzero data");
    stack_cause_a: assert property (stack_fault_reset |-> $past(stack_overflow) || $past(stack_underflow))
        else $error("stack reset without a stack fault");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");
    read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered one cycle after address");
    erase_pulse_a: assert property (program_erase |=> !program_erase)
        else $error("program erase pulse longer than one cycle");
endmodule
bind config_word_decode_code_protect cfg_checker u_chk (.*);
`default_nettype wire

// ===== bench/prog_model.sv
// Programmer-side model: one port cycle per call, returns the answer
`timescale 1ns/1ps
`default_nettype none
module prog_model (
    input  wire logic        aclk, ext_ack, ext_refused, ext_mem_write,
    input  wire logic [13:0] ext_rdata,
    output var  logic        ext_req = 1'b0, ext_write = 1'b0, ext_space = 1'b0,
    output var  logic [13:0] ext_mem_rdata = 14'h0
);
    task automatic access(input logic wr, sp, input logic [13:0] mem,
                          output logic ack, refused, wrote, output logic [13:0] rd);
        @(posedge aclk);
        ext_req <= 1'b1;
        ext_write <= wr;
        ext_space <= sp;
        ext_mem_rdata <= mem;
        @(posedge aclk);
        // Released lines flip so a stale value never looks fresh
        ext_req <= 1'b0;
        ext_write <= ~wr;
        ext_space <= ~sp;
        ext_mem_rdata <= ~mem;
        @(posedge aclk);
        {ack, refused, wrote, rd} = {ext_ack, ext_refused, ext_mem_write, ext_rdata};
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp, clock_source, drive_range, brownout_mode;
    logic [13:0] nv_word_one = 14'h3fff, nv_word_two = 14'h3fff, ext_mem_rdata, ext_rdata;
    logic        stack_overflow = 0, stack_underflow = 0, cpu_pm_rd_req = 0, cpu_pm_wr_req = 0, cpu_ee_req = 0;
    logic [11:0] cpu_pm_wr_addr = 0;
    logic        awready, wready, arready, rvalid, bvalid, clock_pin_gpio, startup_bypass, pll_enable;
    logic        stack_fault_reset, power_up_delay_enable, brownout_trip_select, low_voltage_programming;
    logic        master_clear_hv_required, program_erase, eeprom_erase, config_loaded, cpu_pm_rd_grant;
    logic        cpu_pm_wr_en, cpu_pm_wr_blocked, cpu_ee_grant, ext_mem_write, ext_ack, ext_refused;
    logic        ext_req, ext_write, ext_space;
    int          mismatches = 0, compares = 0, n_perase = 0, n_eerase = 0, seed = 32'h6cbf;

    always #50 aclk = ~aclk;
    config_word_decode_code_protect u_dut (.awprot(3'h0), .arprot(3'h0), .wstrb(4'hf), .*);
    prog_model u_prog (.*);
    always @(posedge aclk) begin
        n_perase <= n_perase + int'(program_erase === 1'b1);
        n_eerase <= n_eerase + int'(eeprom_erase === 1'b1);
    end

    task automatic close_out();
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 0;
                return;
            end
        end
        mismatches++;
        close_out();
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) begin
                {d, r} = {rdata, rresp};
                rready <= 0;
                return;
            end
        end
        mismatches++;
        close_out();
    endtask
    // Words are sampled just after release, so they change only inside reset
    task automatic do_reset(input logic [13:0] a, b);
        @(posedge aclk);
        {aresetn, nv_word_one, nv_word_two} <= {1'b0, a, b};
        repeat (1) @(posedge aclk);
        aresetn <= 1;
        repeat (6) @(posedge aclk);
    endtask
    function automatic logic [5:0] exp_osc(input logic [2:0] c);
        exp_osc[5:4] = c[2] ? (c == 3'h4 ? 2'h1 : 2'h0) : (c == 3'h3 ? 2'h2 : 2'h3);
        exp_osc[3:2] = c >= 3'h5 ? c[1:0] - 2'h1 : c[1:0];
        exp_osc[1:0] = {c == 3'h4, c >= 3'h5};
    endfunction
    function automatic logic exp_block(input logic [1:0] r, input logic [11:0] a);
        exp_block = r == 2'h2 ? a <= 12'h1ff : r == 2'h1 ? a <= 12'h7ff : r == 2'h0;
    endfunction

    initial begin
        logic [13:0] n1, n2, m, rd;
        logic [31:0] d;
        logic [11:0] wa;
        logic [5:0]  e;
        logic [1:0]  r;
        logic        a, f, w, p, b;
        for (int c = 0; c < 8; c++) begin
            n1 = 14'($random(seed));
            n1[2:0] = 3'(c);
            n2 = 14'($random(seed));
            n2[4] = 1'b1;
            n2[1:0] = 2'(c);
            do_reset(n1, n2);
            e = exp_osc(3'(c));
            `CHK({clock_source, clock_pin_gpio, startup_bypass}, {e[5:4], e[1:0]})
            if (c != 3 && c != 4) `CHK(drive_range, e[3:2])
            `CHK({pll_enable, power_up_delay_enable, brownout_mode}, {n2[8], ~n1[5], n1[10:9]})
            `CHK({low_voltage_programming, master_clear_hv_required, brownout_trip_select}, {n2[13], ~n2[13], n2[10]})
            axi_rd(`OFS_CFG_TWO, d, r);
            `CHK({r, d}, {`RESP_OKAY, 18'h0, n2 | 14'h08fc})
            m = 14'($random(seed));
            for (int k = 0; k < 4; k++) begin
                u_prog.access(k[1], k[0], m, a, f, w, rd);
                p = k[0] ? n1[8] : n1[7];
                `CHK({a, f, w}, {1'b1, ~p, k[1] & p})
                if (!k[1]) `CHK(rd, p ? m : 14'h0)
            end
            wa = 12'($random(seed));
            if (c < 4) wa = (c[0] ? 12'h7ff : 12'h1ff) + 12'(c[1]);
            @(posedge aclk);
            {cpu_pm_rd_req, cpu_ee_req, cpu_pm_wr_req, cpu_pm_wr_addr} <= {3'h7, wa};
            {stack_overflow, stack_underflow} <= {c[0], ~c[0]};
            @(posedge aclk);
            {cpu_pm_rd_req, cpu_ee_req, cpu_pm_wr_req, stack_overflow, stack_underflow} <= 5'h0;
            @(posedge aclk);
            b = exp_block(2'(c), wa);
            `CHK({cpu_pm_rd_grant, cpu_ee_grant, cpu_pm_wr_blocked, cpu_pm_wr_en}, {2'h3, b, ~b})
            `CHK(stack_fault_reset, n2[9])
            axi_rd(`OFS_STATUS, d, r);
            `CHK(d, {25'h0, ~n1[8:7], e[0], e[5:4], 2'h3})
            axi_wr(`OFS_CONTROL, 32'h2, r);
            axi_rd(`OFS_STATUS, d, r);
            `CHK({r, d[1:0]}, {`RESP_OKAY, 2'h1})
        end
        n1 = 14'($random(seed));
        n1[8:7] = 2'h0;
        do_reset(n1, 14'h3fff);
        n2 = 14'($random(seed));
        axi_wr(`OFS_CFG_ONE, {18'h0, n2}, r);
        axi_rd(`OFS_CFG_ONE, d, r);
        `CHK({r, d}, {`RESP_OKAY, 18'h0, n1 & n2})
        axi_wr(`OFS_CONTROL, 32'h1, r);
        axi_rd(`OFS_CFG_ONE, d, r);
        `CHK({d, r, n_perase, n_eerase}, {32'h3fff, `RESP_OKAY, 32'd1, 32'd1})
        u_prog.access(1'b0, 1'b1, m, a, f, w, rd);
        `CHK({f, rd}, {1'b0, m})
        axi_rd(8'h10, d, r);
        `CHK({r, d}, {`RESP_SLVERR, 32'h0})
        axi_wr(8'h14, 32'h0, r);
        `CHK(r, `RESP_SLVERR)
        close_out();
    end
endmodule
`default_nettype wire
